// ---- rcl_config_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.svh"

module rcl_config_bank #(
   parameter logic [6:0]  DEV_ADDR        = 7'h20,
   parameter int unsigned TIMEOUT_CYC     = `RCL_TIMEOUT_CYC,
   parameter int unsigned CONV_PERIOD_CYC = `RCL_CONV_PERIOD_CYC
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output var  logic       sda_out,
   output var  logic       sda_oe_n,
   input  wire logic       power_saving_indicator,
   input  wire logic [7:0] vid_pins,
   input  wire logic [7:0] output_voltage_command,
   input  wire logic       fault_event,
   input  wire logic       alert_event,
   output var  logic       fault_n,
   output var  logic       alert_out,
   output var  logic       alert_oe_n,
   output var  logic [2:0] active_phases,
   output var  logic [7:0] vout_target,
   output var  logic       monitor_enable,
   output var  logic       adc_convert_start,
   output var  logic       loop_test_enable,
   output var  logic       bus_timeout_enable,
   output var  logic       write_locked,
   output var  logic       soft_clear
);

   // ===================================================================
   // Pin synchronisers and bus conditions
   logic [1:0] bus_s;
   logic [7:0] vid_s;
   logic       psi_s;
   logic       scl_d;
   logic       sda_d;

   rcl_sync #(.W(2)) u_sync_bus (
      .mclk    (mclk),
      .reset_n (reset_n),
      .d_async ({scl_in, sda_in}),
      .q       (bus_s)
   );

   rcl_sync #(.W(9)) u_sync_pins (
      .mclk    (mclk),
      .reset_n (reset_n),
      .d_async ({power_saving_indicator, vid_pins}),
      .q       ({psi_s, vid_s})
   );

   wire logic scl_s     = bus_s[1];
   wire logic sda_s     = bus_s[0];
   wire logic scl_rise  = scl_s && !scl_d;
   wire logic scl_fall  = !scl_s && scl_d;
   wire logic start_c   = scl_s && scl_d && sda_d && !sda_s;
   wire logic stop_c    = scl_s && scl_d && !sda_d && sda_s;

   // ===================================================================
   // Register state
   logic       lock;
   logic [7:0] cfg_mon;
   logic [7:0] cfg_phase;
   logic [7:0] cfg_dup;
   logic       next_lock;
   logic [7:0] next_cfg_mon;
   logic [7:0] next_cfg_phase;
   logic [7:0] next_cfg_dup;
   logic       next_soft_clear;

   // ===================================================================
   // Serial slave state
   rcl_pkg::rcl_state_t state;
   rcl_pkg::rcl_state_t next_state;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [7:0] cmd;
   logic [7:0] next_cmd;
   logic [7:0] wdata;
   logic [7:0] next_wdata;
   logic       byte_full;
   logic       next_byte_full;
   logic       is_read;
   logic       next_is_read;
   logic       wr_stb;
   logic       next_wr_stb;
   logic       next_sda_oe_n;

   rcl_timeout_if tmo ();

   rcl_bus_timeout #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_timeout (
      .mclk    (mclk),
      .reset_n (reset_n),
      .tif     (tmo.timer)
   );

   assign tmo.run  = cfg_mon[`RCL_BIT_BUS_TO] && (state != rcl_pkg::RCL_IDLE);
   assign tmo.kick = (scl_s ^ scl_d) || (sda_s ^ sda_d);

   function automatic logic [7:0] read_mux(input logic [7:0] code, input logic lk,
                                           input logic [7:0] mon, input logic [7:0] ph,
                                           input logic [7:0] dup);
      logic [7:0] r;
      r = `RCL_READ_UNMAPPED;
      case (code)
         `RCL_OFS_PROTECT:   r = {7'h00, lk};
         `RCL_OFS_MONCFG:    r = mon;
         `RCL_OFS_PHASE:     r = ph;
         `RCL_OFS_PHASE_DUP: r = dup;
         default:            r = `RCL_READ_UNMAPPED;
      endcase
      return r;
   endfunction

   wire logic [7:0] rd_byte = read_mux(cmd, lock, cfg_mon, cfg_phase, cfg_dup);

   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_shreg     = shreg;
      next_cmd       = cmd;
      next_wdata     = wdata;
      next_byte_full = byte_full;
      next_is_read   = is_read;
      next_wr_stb    = 1'b0;
      next_sda_oe_n  = sda_oe_n;
      if (tmo.expired) begin
         next_state    = rcl_pkg::RCL_IDLE;
         next_sda_oe_n = 1'b1;
      end else if (start_c) begin
         next_state     = rcl_pkg::RCL_ADDR;
         next_bit_cnt   = 3'h0;
         next_byte_full = 1'b0;
         next_sda_oe_n  = 1'b1;
      end else if (stop_c) begin
         next_state    = rcl_pkg::RCL_IDLE;
         next_sda_oe_n = 1'b1;
      end else begin
         case (state)
            rcl_pkg::RCL_ADDR, rcl_pkg::RCL_CMD, rcl_pkg::RCL_WDATA: begin
               if (scl_rise) begin
                  next_shreg     = {shreg[6:0], sda_s};
                  next_bit_cnt   = bit_cnt + 3'h1;
                  next_byte_full = (bit_cnt == `RCL_LAST_BIT);
               end else if (scl_fall && byte_full) begin
                  next_byte_full = 1'b0;
                  next_sda_oe_n  = 1'b0;
                  if (state == rcl_pkg::RCL_ADDR) begin
                     next_is_read = shreg[0];
                     if (shreg[7:1] == DEV_ADDR) begin
                        next_state = rcl_pkg::RCL_ADDR_ACK;
                     end else begin
                        next_state    = rcl_pkg::RCL_IDLE;
                        next_sda_oe_n = 1'b1;
                     end
                  end else if (state == rcl_pkg::RCL_CMD) begin
                     next_cmd   = shreg;
                     next_state = rcl_pkg::RCL_CMD_ACK;
                  end else begin
                     // Locked writes still get an acknowledge here.
                     next_wdata  = shreg;
                     next_wr_stb = 1'b1;
                     next_state  = rcl_pkg::RCL_WDATA_ACK;
                  end
               end
            end
            rcl_pkg::RCL_ADDR_ACK, rcl_pkg::RCL_CMD_ACK, rcl_pkg::RCL_WDATA_ACK: begin
               if (scl_fall) begin
                  next_bit_cnt  = 3'h0;
                  next_sda_oe_n = 1'b1;
                  if (state == rcl_pkg::RCL_ADDR_ACK && is_read) begin
                     next_shreg    = rd_byte;
                     next_sda_oe_n = rd_byte[7];
                     next_state    = rcl_pkg::RCL_RDATA;
                  end else if (state == rcl_pkg::RCL_ADDR_ACK) begin
                     next_state = rcl_pkg::RCL_CMD;
                  end else begin
                     next_state = rcl_pkg::RCL_WDATA;
                  end
               end
            end
            rcl_pkg::RCL_RDATA: begin
               if (scl_rise) begin
                  next_bit_cnt   = bit_cnt + 3'h1;
                  next_byte_full = (bit_cnt == `RCL_LAST_BIT);
               end else if (scl_fall && byte_full) begin
                  next_byte_full = 1'b0;
                  next_sda_oe_n  = 1'b1;
                  next_state     = rcl_pkg::RCL_RDATA_ACK;
               end else if (scl_fall) begin
                  next_shreg    = {shreg[6:0], 1'b0};
                  next_sda_oe_n = shreg[6];
               end
            end
            rcl_pkg::RCL_RDATA_ACK: begin
               if (scl_rise && sda_s) begin
                  next_state = rcl_pkg::RCL_IDLE;
               end else if (scl_rise) begin
                  next_byte_full = 1'b1;
               end else if (scl_fall && byte_full) begin
                  next_byte_full = 1'b0;
                  next_bit_cnt   = 3'h0;
                  next_shreg     = rd_byte;
                  next_sda_oe_n  = rd_byte[7];
                  next_state     = rcl_pkg::RCL_RDATA;
               end
            end
            default: begin
               next_state = rcl_pkg::RCL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= rcl_pkg::RCL_IDLE;
         bit_cnt   <= 3'h0;
         shreg     <= 8'h00;
         cmd       <= 8'h00;
         wdata     <= 8'h00;
         byte_full <= 1'b0;
         is_read   <= 1'b0;
         wr_stb    <= 1'b0;
         sda_oe_n  <= 1'b1;
         scl_d     <= 1'b1;
         sda_d     <= 1'b1;
      end else begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         shreg     <= next_shreg;
         cmd       <= next_cmd;
         wdata     <= next_wdata;
         byte_full <= next_byte_full;
         is_read   <= next_is_read;
         wr_stb    <= next_wr_stb;
         sda_oe_n  <= next_sda_oe_n;
         scl_d     <= scl_s;
         sda_d     <= sda_s;
      end
   end

   assign sda_out = 1'b0;

   // ===================================================================
   // Register bank
   // The lock has no clearing path at all; only the power-on reset frees it.
   always_comb begin
      next_lock       = lock;
      next_cfg_mon    = cfg_mon;
      next_cfg_phase  = cfg_phase;
      next_cfg_dup    = cfg_dup;
      next_soft_clear = 1'b0;
      if (wr_stb
          && !lock) begin
         case (cmd)
            `RCL_OFS_PROTECT: begin
               if (wdata[`RCL_BIT_CLEAR]) begin
                  next_cfg_mon    = `RCL_RST_MONCFG;
                  next_cfg_phase  = `RCL_RST_PHASE;
                  next_cfg_dup    = `RCL_RST_PHASE;
                  next_soft_clear = 1'b1;
               end
               next_lock = wdata[`RCL_BIT_LOCK];
            end
            `RCL_OFS_MONCFG:    next_cfg_mon   = wdata & `RCL_MONCFG_MASK;
            `RCL_OFS_PHASE:     next_cfg_phase = wdata;
            `RCL_OFS_PHASE_DUP: next_cfg_dup   = wdata;
            default:            next_lock      = lock;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lock       <= 1'(`RCL_RST_PROTECT);
         cfg_mon    <= `RCL_RST_MONCFG;
         cfg_phase  <= `RCL_RST_PHASE;
         cfg_dup    <= `RCL_RST_PHASE;
         soft_clear <= 1'b0;
      end else begin
         lock       <= next_lock;
         cfg_mon    <= next_cfg_mon;
         cfg_phase  <= next_cfg_phase;
         cfg_dup    <= next_cfg_dup;
         soft_clear <= next_soft_clear;
      end
   end

   // ===================================================================
   // Configuration outputs
   function automatic logic [2:0] psi_phases(input logic [1:0] code);
      logic [2:0] n;
      case (code)
         `RCL_PSI_TWO:   n = `RCL_PHASES_TWO;
         `RCL_PSI_THREE: n = `RCL_PHASES_THREE;
         default:        n = `RCL_PHASES_ONE;
      endcase
      return n;
   endfunction

   function automatic logic [2:0] run_phases(input logic [2:0] code);
      return (code > `RCL_PH_CODE_MAX) ? `RCL_PHASES_MAX : code + 3'h1;
   endfunction

   logic [15:0] conv_cnt;
   logic [15:0] next_conv_cnt;
   logic        next_conv;
   logic [2:0]  next_phases;
   logic [7:0]  next_vout;

   always_comb begin
      next_phases = psi_s ? psi_phases(cfg_mon[`RCL_PSI_HI:`RCL_PSI_LO])
                          : run_phases(cfg_phase[`RCL_PH_HI:`RCL_PH_LO]);
      next_vout   = cfg_phase[`RCL_BIT_VSRC] ? output_voltage_command : vid_s;
      next_conv     = 1'b0;
      next_conv_cnt = 16'h0;
      if (cfg_mon[`RCL_BIT_MON_EN]) begin
         if (conv_cnt == 16'(CONV_PERIOD_CYC - 1)) begin
            next_conv = 1'b1;
         end else begin
            next_conv_cnt = conv_cnt + 16'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conv_cnt           <= 16'h0;
         adc_convert_start  <= 1'b0;
         active_phases      <= `RCL_PHASES_ONE;
         vout_target        <= 8'h00;
         fault_n            <= 1'b1;
         alert_oe_n         <= 1'b1;
         monitor_enable     <= 1'b0;
         loop_test_enable   <= 1'b0;
         bus_timeout_enable <= 1'b0;
         write_locked       <= 1'b0;
      end else begin
         conv_cnt           <= next_conv_cnt;
         adc_convert_start  <= next_conv;
         active_phases      <= next_phases;
         vout_target        <= next_vout;
         fault_n            <= !(fault_event && cfg_mon[`RCL_BIT_FAULT_EN]);
         alert_oe_n         <= !(alert_event && cfg_mon[`RCL_BIT_ALERT_EN]);
         monitor_enable     <= cfg_mon[`RCL_BIT_MON_EN];
         loop_test_enable   <= cfg_phase[`RCL_BIT_LOOP] && cfg_dup[`RCL_BIT_LOOP];
         bus_timeout_enable <= cfg_mon[`RCL_BIT_BUS_TO];
         write_locked       <= lock;
      end
   end

   assign alert_out = 1'b0;

   // ===================================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   wire logic wr_prot = wr_stb && (cmd == `RCL_OFS_PROTECT);

   a_clear_defaults:
      assert property (wr_prot && wdata[`RCL_BIT_CLEAR] && !lock |=> soft_clear
                       && cfg_mon == `RCL_RST_MONCFG && cfg_phase == `RCL_RST_PHASE)
      else $error("soft clear did not restore defaults");
   a_clear_blocked:
      assert property (wr_prot && lock |=> !soft_clear && $stable(cfg_phase)
                       && $stable(cfg_mon))
      else $error("clear acted while locked");
   a_lock_set:
      assert property (wr_prot && wdata[`RCL_BIT_LOCK] |=> lock ##1 write_locked)
      else $error("lock bit not taken");
   a_lock_sticky:
      assert property ($rose(lock) |=> lock [*8])
      else $error("lock released");
   a_psi_phases:
      assert property (psi_s && cfg_mon[`RCL_PSI_HI:`RCL_PSI_LO] == 2'h3
                       |=> active_phases == `RCL_PHASES_ONE)
      else $error("power saving phase count wrong");
   a_timeout_release:
      assert property (tmo.expired |=> state == rcl_pkg::RCL_IDLE && sda_oe_n)
      else $error("bus not released on timeout");
   a_fault_gate:
      assert property (!cfg_mon[`RCL_BIT_FAULT_EN] |=> fault_n)
      else $error("fault driven while disabled");
   a_alert_gate:
      assert property (!cfg_mon[`RCL_BIT_ALERT_EN] |=> alert_oe_n)
      else $error("alert driven while disabled");
   a_monitor_gate:
      assert property (adc_convert_start |-> $past(cfg_mon[`RCL_BIT_MON_EN]))
      else $error("conversion without enable");
   a_phase_count:
      assert property (!psi_s && cfg_phase[`RCL_PH_HI:`RCL_PH_LO] == 3'h7
                       |=> active_phases == `RCL_PHASES_MAX)
      else $error("phase count wrong");
   a_vout_source:
      assert property (cfg_phase[`RCL_BIT_VSRC] |=> vout_target == $past(output_voltage_command))
      else $error("voltage target source wrong");
   a_loop_both:
      assert property (loop_test_enable |-> $past(cfg_dup[`RCL_BIT_LOOP])
                       && $past(cfg_phase[`RCL_BIT_LOOP]))
      else $error("loop test with one copy only");
   a_locked_write:
      assert property (wr_stb && lock |=> $stable(cfg_mon) && $stable(cfg_dup))
      else $error("locked register changed");

   c_lock: cover property (wr_prot && wdata[`RCL_BIT_LOCK] ##1 lock);
   c_clear: cover property (soft_clear);
   c_timeout: cover property (tmo.expired);
   c_read: cover property (state == rcl_pkg::RCL_RDATA_ACK);

endmodule

`default_nettype wire

// ---- rcl_regs.svh ----
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH

// ======================================================================
// Register offsets (command codes)
`define RCL_OFS_PROTECT     8'hD0
`define RCL_OFS_MONCFG      8'hD1
`define RCL_OFS_PHASE       8'hD2
`define RCL_OFS_PHASE_DUP   8'hD3

// ======================================================================
// Reset values, write mask and unmapped read value
`define RCL_RST_PROTECT     8'h00
`define RCL_RST_MONCFG      8'h07
`define RCL_RST_PHASE       8'h52
`define RCL_MONCFG_MASK     8'hCF
`define RCL_READ_UNMAPPED   8'h00

// ======================================================================
// Field positions
`define RCL_BIT_LOCK        0
`define RCL_BIT_CLEAR       1
`define RCL_PSI_HI          7
`define RCL_PSI_LO          6
`define RCL_BIT_BUS_TO      3
`define RCL_BIT_FAULT_EN    2
`define RCL_BIT_ALERT_EN    1
`define RCL_BIT_MON_EN      0
`define RCL_PH_HI           6
`define RCL_PH_LO           4
`define RCL_BIT_VSRC        3
`define RCL_BIT_LOOP        2

// ======================================================================
// Encodings and counts
`define RCL_PSI_ONE_A       2'h0
`define RCL_PSI_TWO         2'h1
`define RCL_PSI_THREE       2'h2
`define RCL_PH_CODE_MAX     3'h5
`define RCL_PHASES_MAX      3'h6
`define RCL_PHASES_ONE      3'h1
`define RCL_PHASES_TWO      3'h2
`define RCL_PHASES_THREE    3'h3
`define RCL_LAST_BIT        3'h7

// ======================================================================
// Timing
`define RCL_CLK_HZ          20000000
`define RCL_BUS_TIMEOUT_MS  35
`define RCL_TIMEOUT_CYC     (`RCL_BUS_TIMEOUT_MS * (`RCL_CLK_HZ / 1000))
`define RCL_CONV_PERIOD_CYC 2000

`endif

// ---- rcl_pkg.sv ----
`default_nettype none

package rcl_pkg;

   // Gray coded along the write path, read path branches off the tail.
   typedef enum logic [3:0] {
      RCL_IDLE      = 4'h0,
      RCL_ADDR      = 4'h1,
      RCL_ADDR_ACK  = 4'h3,
      RCL_CMD       = 4'h2,
      RCL_CMD_ACK   = 4'h6,
      RCL_WDATA     = 4'h7,
      RCL_WDATA_ACK = 4'h5,
      RCL_RDATA     = 4'h4,
      RCL_RDATA_ACK = 4'hC
   } rcl_state_t;

endpackage

`default_nettype wire

// ---- rcl_timeout_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface rcl_timeout_if;
   logic run;
   logic kick;
   logic expired;

   modport ctrl  (output run, output kick, input expired);
   modport timer (input run, input kick, output expired);
endinterface

`default_nettype wire

// ---- rcl_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module rcl_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d_async,
   output var  logic [W-1:0] q
);

   logic [W-1:0] stage1;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= '1;
         q      <= '1;
      end else begin
         stage1 <= d_async;
         q      <= stage1;
      end
   end

endmodule

`default_nettype wire

// ---- rcl_bus_timeout.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.svh"

module rcl_bus_timeout #(
   parameter int unsigned TIMEOUT_CYC = `RCL_TIMEOUT_CYC
) (
   input  wire logic    mclk,
   input  wire logic    reset_n,
   rcl_timeout_if.timer tif
);

   logic [31:0] cnt;
   logic [31:0] next_cnt;

   // The counter saturates so a stuck bus gives a steady expiry level.
   always_comb begin
      next_cnt = cnt;
      if (!tif.run || tif.kick) begin
         next_cnt = 32'h0;
      end else if (cnt != TIMEOUT_CYC) begin
         next_cnt = cnt + 32'h1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 32'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign tif.expired = tif.run && !tif.kick && (cnt == TIMEOUT_CYC);

endmodule

`default_nettype wire

// ---- rcl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcl_host_model #(
   parameter logic [6:0] ADDR = 7'h20
) (
   input  wire logic mclk,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_drv
);
   // ==================================================
   // Bus master
   // A high sda_drv only lets go of the line, as on an open-drain pin.
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Start when a is one, stop when zero; SDA moves while SCL is high.
   task automatic cond(input logic a);
      sda_drv = a;
      hw(6);
      scl = 1'b1;
      hw(6);
      sda_drv = ~a;
      hw(6);
      scl = ~a;
   endtask
   // Half periods of 6 cycles leave margin over the 4 cycle minimum.
   task automatic bit_io(input logic b, output logic s);
      sda_drv = b;
      hw(6);
      scl = 1'b1;
      hw(3);
      s = sda_line;
      hw(3);
      scl = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
   endtask
   // Sends a byte and its acknowledge slot; a high slot clears ok.
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, inout logic ok);
      logic a;
      byte_io(d, q);
      bit_io(1'b1, a);
      ok = ok & ~a;
   endtask
   task automatic wr_reg(input logic [7:0] c, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      ok = 1'b1;
      cond(1'b1);
      xfer({ADDR, 1'b0}, q, ok);
      xfer(c, q, ok);
      xfer(d, q, ok);
      cond(1'b0);
   endtask
   // The read ends with a not-acknowledge so the device drops back to idle.
   task automatic rd_reg(input logic [7:0] c, output logic [7:0] q);
      logic ok;
      ok = 1'b1;
      cond(1'b1);
      xfer({ADDR, 1'b0}, q, ok);
      xfer(c, q, ok);
      cond(1'b1);
      xfer({ADDR, 1'b1}, q, ok);
      xfer(8'hFF, q, ok);
      cond(1'b0);
   endtask
endmodule
`default_nettype wire

// ---- rcl_config_bank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module rcl_config_bank_tb;
   logic       mclk, reset_n, ps_ind, fault_event, alert_event, ok;
   logic [7:0] ext_code, ovc, q;
   int         miscompares, checks_done, cycles, pulses, clears;
   wire logic  scl, sda_drv, sda_out, sda_oe_n, fault_n, alert_oe_n, write_locked;
   wire logic  monitor_enable, adc_convert_start, loop_test_enable;
   wire logic  alert_out, bus_timeout_enable, soft_clear;
   wire logic [2:0] active_phases;
   wire logic [7:0] vout_target;
   // ==================================================
   // Bus wiring
   // The line is low while either party pulls it, otherwise the pull-up wins.
   wire logic  sda = sda_drv & (sda_oe_n | sda_out);
   logic [23:0] rows [5] = '{24'hD1_0F_0F, 24'hD1_FF_CF, 24'hD2_7A_7A, 24'hD3_61_61, 24'hE0_5A_00};
   logic [7:0] rst_val [4] = '{8'h00, 8'h07, 8'h52, 8'h52};
   logic [2:0] save_ph [4] = '{3'h1, 3'h2, 3'h3, 3'h1};
   rcl_config_bank #(.TIMEOUT_CYC(200), .CONV_PERIOD_CYC(8)) i_rcl_config_bank (
      .mclk, .reset_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
      .power_saving_indicator(ps_ind), .vid_pins(ext_code), .output_voltage_command(ovc),
      .fault_event, .alert_event, .fault_n, .alert_out, .alert_oe_n, .active_phases,
      .vout_target, .monitor_enable, .adc_convert_start, .loop_test_enable,
      .bus_timeout_enable, .write_locked, .soft_clear);
   rcl_host_model i_rcl_host_model (.mclk, .sda_line(sda), .scl, .sda_drv);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      pulses += int'(adc_convert_start === 1'b1);
      clears += int'(soft_clear === 1'b1);
      if (cycles == 40000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      i_rcl_host_model.wr_reg(c, d, ok);
      `CHK("write ack", 1'b1, ok)
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] e);
      i_rcl_host_model.rd_reg(c, q);
      `CHK("register", e, q)
   endtask
   task automatic done(input string t);
      $display("end of test %s", t);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      ps_ind = 1'b0;
      ext_code = 8'h3C;
      ovc = 8'hA5;
      fault_event = 1'b0;
      alert_event = 1'b0;
      repeat (10) @(negedge mclk);
      reset_n = 1'b1;
      i_rcl_host_model.hw(4);
      `CHK("phases", 3'h6, active_phases)
      for (int i = 0; i < 4; i++) begin
         rd(8'hD0 + 8'(i), rst_val[i]);
      end
      done("reset");
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      done("table");
      for (int c = 0; c < 8; c++) begin
         wr(8'hD2, {1'b0, 3'(c), 4'h0});
         `CHK("phases", (c > 5) ? 3'h6 : 3'(c + 1), active_phases)
      end
      ps_ind = 1'b1;
      for (int f = 0; f < 4; f++) begin
         wr(8'hD1, {2'(f), 6'h07});
         `CHK("saving phases", save_ph[f], active_phases)
      end
      ps_ind = 1'b0;
      done("phases");
      wr(8'hD2, 8'h08);
      `CHK("target", ovc, vout_target)
      ovc = 8'h5A;
      i_rcl_host_model.hw(4);
      `CHK("target", 8'h5A, vout_target)
      wr(8'hD2, 8'h04);
      `CHK("target", ext_code, vout_target)
      ext_code = 8'hC3;
      i_rcl_host_model.hw(4);
      `CHK("target", 8'hC3, vout_target)
      `CHK("loop", 1'b0, loop_test_enable)
      wr(8'hD3, 8'h04);
      `CHK("loop", 1'b1, loop_test_enable)
      done("source and loop");
      fault_event = 1'b1;
      alert_event = 1'b1;
      wr(8'hD1, 8'h04);
      pulses = 0;
      i_rcl_host_model.hw(24);
      `CHK("fault pin", 1'b0, fault_n)
      `CHK("alert pin", 1'b1, alert_oe_n)
      `CHK("conversions", 0, pulses)
      `CHK("monitor", 1'b0, monitor_enable)
      wr(8'hD1, 8'h03);
      pulses = 0;
      i_rcl_host_model.hw(24);
      `CHK("fault pin", 1'b1, fault_n)
      `CHK("alert pin", 1'b0, alert_oe_n)
      `CHK("conversions", 3, pulses)
      `CHK("monitor", 1'b1, monitor_enable)
      `CHK("alert level", 1'b0, alert_out)
      done("pins");
      wr(8'hD1, 8'h08);
      `CHK("timeout enable", 1'b1, bus_timeout_enable)
      i_rcl_host_model.cond(1'b1);
      i_rcl_host_model.byte_io({7'h20, 1'b0}, q);
      i_rcl_host_model.hw(6);
      `CHK("ack drive", 1'b0, sda_oe_n)
      i_rcl_host_model.hw(250);
      `CHK("bus released", 1'b1, sda_oe_n)
      i_rcl_host_model.cond(1'b0);
      done("timeout");
      wr(8'hD0, 8'h02);
      `CHK("clear pulses", 1, clears)
      `CHK("timeout enable", 1'b0, bus_timeout_enable)
      rd(8'hD1, 8'h07);
      rd(8'hD3, 8'h52);
      wr(8'hD1, 8'h0B);
      wr(8'hD0, 8'h01);
      `CHK("lock", 1'b1, write_locked)
      wr(8'hD1, 8'h00);
      rd(8'hD1, 8'h0B);
      wr(8'hD0, 8'h02);
      rd(8'hD1, 8'h0B);
      `CHK("clear pulses", 1, clears)
      wr(8'hD0, 8'h00);
      rd(8'hD0, 8'h01);
      done("lock");
      reset_n = 1'b0;
      i_rcl_host_model.hw(3);
      `CHK("lock in reset", 1'b0, write_locked)
      reset_n = 1'b1;
      i_rcl_host_model.hw(4);
      rd(8'hD0, 8'h00);
      rd(8'hD1, 8'h07);
      `CHK("clear pulses", 1, clears)
      done("power cycle");
      complete_run();
   end
endmodule
`default_nettype wire
